// ==== hw/oss_pkg.sv ====
// Purpose: shared constants for the oscillator source selector
// Assumes: 25 MHz clk, AHB-Lite register access, word-aligned byte offsets
// Notes: oscillator outputs are one-cycle ticks in the clk domain
// How it works
// RQ1: fast source bit picks crystal or RC
// RQ2: fast RC runs only while enabled
// RQ3: two-bit field picks 4, 8, 12 MHz
// RQ4: software matches RC setting to option
// RQ5: slow select bit may pick watch crystal
// RQ6: watch crystal usable after start-up count
// RQ7: speed-up bit one fast, zero low power
// RQ8: clearing speed-up keeps crystal running
// RQ9: speed-up frozen while crystal clocks system
// RQ10: low power only lengthens start-up
// RQ11: select field switches clock at run time
// RQ12: every encoding has a real source
// RQ13: slow RC is other slow choice
// RQ14: pin bits give crystal pins or I/O
// RQ15: halted modes gate the system clock
// RQ16: slow clock feeds watchdog, LCD, time base
// RQ17: codes 0-6 divide fast, 7 slow
// RQ18: halt keep bits pick sleep or idle
// RQ19: source switch only at period boundary; the code also switches at once when the old source is not ready
// RQ20: no switch before target is ready
package oss_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] REG_SYSCLK = 8'h00;
    localparam logic [7:0] REG_FASTRC = 8'h04;
    localparam logic [7:0] REG_WATCH = 8'h08;
    localparam logic [7:0] REG_FASTXTAL = 8'h0C;
    localparam logic [7:0] REG_PINS = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] ADDR_NONE = 8'hFF;
    // ==========================================================
    // Field positions
    localparam int SYS_SEL_LSB = 5;
    localparam int SYS_HS = 3;
    localparam int SYS_LS = 2;
    localparam int SYS_FKEEP = 1;
    localparam int SYS_SKEEP = 0;
    localparam logic [7:0] SYS_MASK = 8'hEF;
    localparam int FRC_EN = 0;
    localparam int FRC_RDY = 1;
    localparam int FRC_FRQ_LSB = 2;
    localparam int WX_EN = 0;
    localparam int WX_SPD = 1;
    localparam int WX_RDY = 2;
    localparam int FX_EN = 0;
    localparam int FX_RDY = 1;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int ST_MODE_LSB = 5;
    // ==========================================================
    // Reset values and codes
    localparam logic [7:0] SYS_RST = 8'h00;
    localparam logic FRC_EN_RST = 1'b1;
    localparam logic [1:0] FRQ_RST = 2'h0;
    localparam logic [1:0] FRQ_BAD = 2'h3;
    localparam logic WX_SPD_RST = 1'b1;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    localparam logic [2:0] SEL_DIV1 = 3'h0;
    // ==========================================================
    // Start-up counts, in oscillator ticks
    localparam int FX_START = 1024;
    localparam int FRC_START = 16;
    localparam int WX_START_SPD = 1024;
    localparam int WX_START_LOW = 8192;
    // ==========================================================
    // Oscillator slots and modes
    localparam int OSC_FX = 0;
    localparam int OSC_FRC = 1;
    localparam int OSC_WX = 2;
    localparam int N_OSC = 3;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_IDLE = 2'h1,
        ST_SLEEP = 2'h3
    } oss_mode_e;
endpackage

// ==== hw/oss_osc_if.sv ====
// Purpose: start-up handshake between selector and start-up counter
// Assumes: all signals in the clk domain
// Notes: ready is registered in the counter
`timescale 1ns/1ns
interface oss_osc_if #(parameter int W = 16);
    logic run;
    logic tick;
    logic ready;
    logic [W-1:0] limit;
    modport ctrl (output run, output tick, output limit, input ready);
    modport cnt (input run, input tick, input limit, output ready);
endinterface

// ==== hw/oss_startup.sv ====
// Purpose: counts oscillator ticks until the source is usable
// Assumes: tick pulses only while the oscillator runs
// Notes: ready stays set until run drops
`timescale 1ns/1ns
module oss_startup #(
    parameter int W = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Oscillator handshake
    oss_osc_if.cnt osc
);
    // ==========================================================
    // Elaboration check
    if (W < 2) begin : g_bad_w
        $error("oss_startup: W too small");
    end

    // ==========================================================
    // Counter
    logic [W-1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d;

    assign osc.ready = rdy_q;

    always_comb begin
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        if (!osc.run) begin
            cnt_d = '0;
            rdy_d = 1'b0;
        end else begin
            if (osc.tick && cnt_q < osc.limit) begin
                cnt_d = cnt_q + 1'b1; // RQ6 RQ10
            end
            // Sticky, so a longer limit later cannot drop it
            if (cnt_q >= osc.limit) begin
                rdy_d = 1'b1; // RQ8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end
endmodule // oss_startup

// ==== hw/oss_top.sv ====
// Purpose: oscillator enables, source selection and system clock ticks
// Assumes: oscillator ticks synchronous to clk, one cycle wide
// Notes: clocks leave as enable ticks, never as gated clocks
`timescale 1ns/1ns
module oss_top import oss_pkg::*; #(
    parameter int CW = 16,
    parameter int FX_CYC = FX_START,
    parameter int FRC_CYC = FRC_START,
    parameter int WX_SPD_CYC = WX_START_SPD,
    parameter int WX_LOW_CYC = WX_START_LOW
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Oscillator ticks
    input wire logic ext_fast_crystal_tick,
    input wire logic int_fast_rc_tick,
    input wire logic watch_crystal_tick,
    input wire logic int_slow_rc_tick,
    // CPU and watchdog
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic wdt_enable,
    // Oscillator controls
    output logic ext_fast_crystal_run,
    output logic int_fast_rc_run,
    output logic watch_crystal_run,
    output logic int_slow_rc_run,
    output logic [1:0] fast_rc_freq_select,
    output logic watch_crystal_speedup,
    output logic watch_crystal_pin_a_osc,
    output logic watch_crystal_pin_b_osc,
    // Clock ticks and status
    output logic sys_tick,
    output logic fast_periph_tick,
    output logic slow_periph_tick,
    output logic cpu_halted
);
    // ==========================================================
    // Elaboration check
    if (FX_CYC >= 2**CW || FRC_CYC >= 2**CW ||
        WX_SPD_CYC >= 2**CW || WX_LOW_CYC >= 2**CW ||
        FX_CYC < 1 || FRC_CYC < 1 || WX_SPD_CYC < 1 ||
        WX_LOW_CYC < 1) begin : g_bad_cnt
        $error("oss_top: start-up count does not fit CW");
    end

    // ==========================================================
    // Start-up counters
    oss_osc_if #(.W(CW)) osc [N_OSC] ();

    logic fx_run_q, frc_run_q, wx_run_q, sr_run_q;
    logic fx_en_q, frc_en_q, wx_en_q, wx_spd_q;
    logic fx_rdy, frc_rdy, wx_rdy;

    assign osc[OSC_FX].run = fx_run_q;
    assign osc[OSC_FX].tick = ext_fast_crystal_tick;
    assign osc[OSC_FX].limit = CW'(FX_CYC);
    assign osc[OSC_FRC].run = frc_run_q;
    assign osc[OSC_FRC].tick = int_fast_rc_tick;
    assign osc[OSC_FRC].limit = CW'(FRC_CYC);
    assign osc[OSC_WX].run = wx_run_q;
    assign osc[OSC_WX].tick = watch_crystal_tick;
    // Low power only lengthens start-up
    assign osc[OSC_WX].limit = wx_spd_q ? CW'(WX_SPD_CYC)
                                        : CW'(WX_LOW_CYC); // RQ7 RQ10
    assign fx_rdy = osc[OSC_FX].ready;
    assign frc_rdy = osc[OSC_FRC].ready;
    assign wx_rdy = osc[OSC_WX].ready;

    for (genvar i = 0; i < N_OSC; i++) begin : g_osc
        oss_startup #(.W(CW)) u_startup (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .osc(osc[i])
        );
    end

    // ==========================================================
    // Source decode
    function automatic logic [5:0] div_mask(input logic [2:0] s);
        div_mask = 6'((7'h01 << s) - 7'h01);
    endfunction

    // Single-bit selects: no code can name a missing source
    // Readiness comes in as r, slow RC on top: an assign sees only args
    function automatic logic src_ok(input logic [2:0] s,
                                    input logic h,
                                    input logic l, input logic [3:0] r);
        if (s == SEL_SLOW) begin
            src_ok = l ? r[OSC_WX] : r[N_OSC]; // RQ12
        end else begin
            src_ok = h ? r[OSC_FX] : r[OSC_FRC]; // RQ12
        end
    endfunction

    // ==========================================================
    // AHB-Lite slave
    logic dp_wr_q, dp_wr_d, dp_rd_q, dp_rd_d;
    logic [7:0] dp_addr_q, dp_addr_d;
    logic rdy_q, rdy_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] rword;
    logic take;
    logic [7:0] sys_q;
    logic [1:0] frq_q;
    logic pin_a_q, pin_b_q;
    oss_mode_e mode_q;
    logic [2:0] act_sel_q;
    logic act_hs_q, act_ls_q;

    assign take = hsel && hready && htrans[1];

    always_comb begin
        rword = 32'h0000_0000;
        unique case (dp_addr_q)
            REG_SYSCLK: rword[7:0] = sys_q;
            REG_FASTRC: begin
                rword[FRC_EN] = frc_en_q;
                rword[FRC_RDY] = frc_rdy;
                rword[FRC_FRQ_LSB +: 2] = frq_q;
            end
            REG_WATCH: begin
                rword[WX_EN] = wx_en_q;
                rword[WX_SPD] = wx_spd_q;
                rword[WX_RDY] = wx_rdy;
            end
            REG_FASTXTAL: begin
                rword[FX_EN] = fx_en_q;
                rword[FX_RDY] = fx_rdy;
            end
            REG_PINS: begin
                rword[PIN_A] = pin_a_q;
                rword[PIN_B] = pin_b_q;
            end
            REG_STAT: begin
                rword[2:0] = act_sel_q;
                rword[SYS_LS] = act_ls_q;
                rword[SYS_HS] = act_hs_q;
                rword[ST_MODE_LSB +: 2] = mode_q;
            end
            default: rword = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so a write just before lands first
    always_comb begin
        dp_wr_d = 1'b0;
        dp_rd_d = dp_rd_q;
        dp_addr_d = dp_addr_q;
        rdy_d = rdy_q;
        rdata_d = rdata_q;
        if (dp_rd_q) begin
            rdata_d = rword;
            rdy_d = 1'b1;
            dp_rd_d = 1'b0;
        end
        if (take) begin
            dp_addr_d = (|haddr[31:8] || |haddr[1:0]) ? ADDR_NONE
                                                      : haddr[7:0];
            dp_wr_d = hwrite;
            dp_rd_d = !hwrite;
            rdy_d = hwrite;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= ADDR_NONE;
            rdy_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            dp_wr_q <= dp_wr_d;
            dp_rd_q <= dp_rd_d;
            dp_addr_q <= dp_addr_d;
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = rdy_q;
    assign hresp = 1'b0;

    // ==========================================================
    // Control registers
    logic [7:0] sys_d;
    logic [1:0] frq_d;
    logic fx_en_d, frc_en_d, wx_en_d, wx_spd_d;
    logic pin_a_d, pin_b_d;
    logic wx_lock;

    assign wx_lock = (sys_q[SYS_SEL_LSB +: 3] == SEL_SLOW && sys_q[SYS_LS])
                  || (act_sel_q == SEL_SLOW && act_ls_q);

    always_comb begin
        sys_d = sys_q;
        frq_d = frq_q;
        fx_en_d = fx_en_q;
        frc_en_d = frc_en_q;
        wx_en_d = wx_en_q;
        wx_spd_d = wx_spd_q;
        pin_a_d = pin_a_q;
        pin_b_d = pin_b_q;
        if (dp_wr_q) begin
            unique case (dp_addr_q)
                REG_SYSCLK: sys_d = hwdata[7:0] & SYS_MASK; // RQ11
                REG_FASTRC: begin
                    frc_en_d = hwdata[FRC_EN];
                    // Unused code keeps the old setting
                    if (hwdata[FRC_FRQ_LSB +: 2] != FRQ_BAD) begin
                        frq_d = hwdata[FRC_FRQ_LSB +: 2]; // RQ3
                    end
                end
                REG_WATCH: begin
                    wx_en_d = hwdata[WX_EN];
                    if (!wx_lock) begin
                        wx_spd_d = hwdata[WX_SPD]; // RQ9
                    end
                end
                REG_FASTXTAL: fx_en_d = hwdata[FX_EN];
                REG_PINS: begin
                    pin_a_d = hwdata[PIN_A]; // RQ14
                    pin_b_d = hwdata[PIN_B]; // RQ14
                end
                default: sys_d = sys_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sys_q <= SYS_RST;
            frq_q <= FRQ_RST;
            fx_en_q <= 1'b0;
            frc_en_q <= FRC_EN_RST;
            wx_en_q <= 1'b0;
            wx_spd_q <= WX_SPD_RST;
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else if (ce) begin
            sys_q <= sys_d;
            frq_q <= frq_d;
            fx_en_q <= fx_en_d;
            frc_en_q <= frc_en_d;
            wx_en_q <= wx_en_d;
            wx_spd_q <= wx_spd_d;
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
        end
    end

    // ==========================================================
    // Mode, source switch and clock ticks
    oss_mode_e mode_d;
    logic [2:0] act_sel_d;
    logic act_hs_d, act_ls_d;
    logic [5:0] div_q, div_d;
    logic fast_on, slow_on, fh_raw, fs_raw, hs_fire, src_tick;
    logic cur_ok, tgt_ok, commit;
    logic [3:0] src_rdy;
    logic [2:0] req_sel;
    logic sys_tick_q, fh_tick_q, fs_tick_q, halted_q;

    assign req_sel = sys_q[SYS_SEL_LSB +: 3];
    assign fast_on = mode_q == ST_RUN
                  || (mode_q == ST_IDLE && sys_q[SYS_FKEEP]);
    assign slow_on = mode_q == ST_RUN || wdt_enable
                  || (mode_q == ST_IDLE && sys_q[SYS_SKEEP]);
    assign fh_raw = act_hs_q ? ext_fast_crystal_tick && fx_rdy
                             : int_fast_rc_tick && frc_rdy; // RQ1
    assign fs_raw = act_ls_q ? watch_crystal_tick && wx_rdy // RQ5
                             : int_slow_rc_tick && sr_run_q; // RQ13
    assign hs_fire = fh_raw
                  && (div_q & div_mask(act_sel_q)) == div_mask(act_sel_q);
    assign src_tick = act_sel_q == SEL_SLOW ? fs_raw : hs_fire; // RQ17
    assign src_rdy = {sr_run_q, wx_rdy, frc_rdy, fx_rdy};
    assign cur_ok = src_ok(act_sel_q, act_hs_q, act_ls_q, src_rdy);
    assign tgt_ok = src_ok(req_sel, sys_q[SYS_HS], sys_q[SYS_LS], src_rdy);
    // Switch at a period end, or when the old source is silent
    assign commit = (req_sel != act_sel_q || sys_q[SYS_HS] != act_hs_q
                     || sys_q[SYS_LS] != act_ls_q)
                 && tgt_ok && (src_tick || !cur_ok); // RQ19 RQ20

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            ST_RUN: if (halt_req) begin
                mode_d = (sys_q[SYS_FKEEP] || sys_q[SYS_SKEEP])
                       ? ST_IDLE : ST_SLEEP; // RQ18
            end
            ST_IDLE, ST_SLEEP: if (wake_req) begin
                mode_d = ST_RUN;
            end
            default: mode_d = ST_RUN;
        endcase
    end

    always_comb begin
        act_sel_d = act_sel_q;
        act_hs_d = act_hs_q;
        act_ls_d = act_ls_q;
        div_d = fh_raw ? div_q + 6'h01 : div_q;
        if (commit) begin
            act_sel_d = req_sel; // RQ11
            act_hs_d = sys_q[SYS_HS];
            act_ls_d = sys_q[SYS_LS];
            div_d = 6'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_q <= ST_RUN;
            act_sel_q <= SEL_DIV1;
            act_hs_q <= 1'b0;
            act_ls_q <= 1'b0;
            div_q <= 6'h00;
            fx_run_q <= 1'b0;
            frc_run_q <= 1'b0;
            wx_run_q <= 1'b0;
            sr_run_q <= 1'b0;
            sys_tick_q <= 1'b0;
            fh_tick_q <= 1'b0;
            fs_tick_q <= 1'b0;
            halted_q <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            act_sel_q <= act_sel_d;
            act_hs_q <= act_hs_d;
            act_ls_q <= act_ls_d;
            div_q <= div_d;
            fx_run_q <= fx_en_q && fast_on; // RQ1
            frc_run_q <= frc_en_q && fast_on; // RQ2
            wx_run_q <= wx_en_q && slow_on; // RQ5
            sr_run_q <= slow_on;
            sys_tick_q <= src_tick && mode_q == ST_RUN; // RQ15
            fh_tick_q <= fh_raw;
            fs_tick_q <= fs_raw; // RQ16
            halted_q <= mode_d != ST_RUN;
        end
    end

    assign ext_fast_crystal_run = fx_run_q;
    assign int_fast_rc_run = frc_run_q;
    assign watch_crystal_run = wx_run_q;
    assign int_slow_rc_run = sr_run_q;
    assign fast_rc_freq_select = frq_q;
    assign watch_crystal_speedup = wx_spd_q;
    assign watch_crystal_pin_a_osc = pin_a_q;
    assign watch_crystal_pin_b_osc = pin_b_q;
    assign sys_tick = sys_tick_q;
    assign fast_periph_tick = fh_tick_q;
    assign slow_periph_tick = fs_tick_q;
    assign cpu_halted = halted_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_halt_sleep;
        ce && mode_q == ST_RUN && halt_req
        && !sys_q[SYS_FKEEP] && !sys_q[SYS_SKEEP];
    endsequence
    sequence s_halt_idle;
        ce && mode_q == ST_RUN && halt_req
        && (sys_q[SYS_FKEEP] || sys_q[SYS_SKEEP]);
    endsequence

    chk_halt_sleep: assert property (s_halt_sleep |=> // RQ18
        mode_q == ST_SLEEP && cpu_halted)
        else $error("halt without keep bits did not sleep");
    chk_halt_idle: assert property (s_halt_idle |=> // RQ18
        mode_q == ST_IDLE && cpu_halted)
        else $error("halt with keep bit did not idle");
    chk_sys_gated: assert property ( // RQ15
        ce && mode_q != ST_RUN |=> !sys_tick)
        else $error("system tick while halted");
    chk_div_one: assert property ( // RQ17
        ce && mode_q == ST_RUN && act_sel_q == SEL_DIV1 && fh_raw
        |=> sys_tick)
        else $error("undivided fast tick missing");
    chk_slow_sys: assert property ( // RQ17
        ce && mode_q == ST_RUN && act_sel_q == SEL_SLOW && fs_raw
        |=> sys_tick)
        else $error("slow system tick missing");
    chk_switch_ready: assert property ( // RQ20
        $changed(act_sel_q) || $changed(act_hs_q) || $changed(act_ls_q)
        |-> $past(tgt_ok))
        else $error("switched to a source not yet ready");
    chk_switch_edge: assert property ( // RQ19
        $changed(act_sel_q) || $changed(act_hs_q) || $changed(act_ls_q)
        |-> $past(src_tick) || !$past(cur_ok))
        else $error("switch cut a clock period short");
    chk_spd_lock: assert property ( // RQ9
        ce && dp_wr_q && dp_addr_q == REG_WATCH && wx_lock
        |=> $stable(wx_spd_q))
        else $error("speed-up changed while crystal clocks system");
    chk_frq_keep: assert property ( // RQ3
        ce && dp_wr_q && dp_addr_q == REG_FASTRC
        && hwdata[FRC_FRQ_LSB +: 2] == FRQ_BAD |=> $stable(frq_q))
        else $error("unused frequency code was taken");
    chk_rc_off: assert property ( // RQ2
        ce && !frc_en_q |=> !int_fast_rc_run)
        else $error("fast RC runs while disabled");
    chk_xtal_off: assert property ( // RQ1
        ce && !fx_en_q |=> !ext_fast_crystal_run)
        else $error("fast crystal runs while disabled");
    chk_wx_hold: assert property ( // RQ8
        ce && wx_rdy && wx_run_q |=> wx_rdy)
        else $error("watch crystal lost ready while running");
    chk_wx_start: assert property ( // RQ6
        ce && !wx_run_q |=> !wx_rdy)
        else $error("watch crystal ready without running");
    chk_slow_route: assert property ( // RQ16
        ce && fs_raw |=> slow_periph_tick)
        else $error("slow tick not routed to peripherals");
endmodule // oss_top

// ==== testbench/oss_osc_model.sv ====
// Purpose: the four oscillators seen from the selector, as clk ticks
// Assumes: run is registered by the selector
// Notes: low power only stretches the start-up, never stops the ticks
`timescale 1ns/1ns
module oss_osc_model (
    // Clock and control
    input wire logic clk,
    input wire logic [3:0] run,
    input wire logic low_power,
    // Ticks: fast crystal, fast RC, watch crystal, slow RC
    output wire logic [3:0] tick
);
    localparam int P [4] = '{2, 3, 5, 7};
    for (genvar i = 0; i < 4; i++) begin : g_osc
        int cnt = 0;
        int wake = 0;
        bit up = 0;
        // Combinational so no tick survives run falling
        assign tick[i] = run[i] && up && cnt == P[i] - 1;
        always @(posedge clk) begin
            if (!run[i]) begin
                cnt <= 0;
                wake <= 0;
                up <= 0;
            end else if (!up) begin
                // Once up, a mode change never stalls the ticks
                wake <= wake + 1;
                up <= wake >= ((i == 2 && low_power) ? 7 : 1);
            end else begin
                cnt <= (cnt == P[i] - 1) ? 0 : cnt + 1;
            end
        end
    end
endmodule // oss_osc_model

// ==== testbench/tb_oss_top.sv ====
// Purpose: self-checking bench for the oscillator source selector
// Assumes: small start-up counts, oscillator models in the clk domain
// Notes: status reads are masked to the bits that stand alone
`timescale 1ns/1ns
module tb_oss_top import oss_pkg::*;;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
    logic clk = 0, rstn = 0, ce = 1, hsel = 0, hwrite = 0, hready;
    logic halt_req = 0, wake_req = 0, wdt_enable = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0, fsel;
    logic hreadyout, hresp, fx_r, frc_r, wx_r;
    logic [3:0] ot;
    logic src_r, wx_spd, pin_a, pin_b, sys_tick, fp_t, slow_periph_tick;
    logic cpu_halted;
    int fails = 0, tests_run = 0, cycles = 0, g, ns, nl, nf;
    assign hready = hreadyout;
    oss_top #(.FX_CYC(4), .FRC_CYC(2), .WX_SPD_CYC(4), .WX_LOW_CYC(8)) uut (
        .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_fast_crystal_tick(ot[0]),
        .int_fast_rc_tick(ot[1]), .watch_crystal_tick(ot[2]),
        .int_slow_rc_tick(ot[3]), .halt_req(halt_req), .wake_req(wake_req),
        .wdt_enable(wdt_enable), .ext_fast_crystal_run(fx_r),
        .int_fast_rc_run(frc_r), .watch_crystal_run(wx_r),
        .int_slow_rc_run(src_r), .fast_rc_freq_select(fsel),
        .watch_crystal_speedup(wx_spd), .watch_crystal_pin_a_osc(pin_a),
        .watch_crystal_pin_b_osc(pin_b), .sys_tick(sys_tick),
        .fast_periph_tick(fp_t), .slow_periph_tick(slow_periph_tick),
        .cpu_halted(cpu_halted));
    oss_osc_model m_osc (.clk(clk), .run({src_r, wx_r, frc_r, fx_r}),
        .low_power(!wx_spd), .tick(ot));
    // ==========================================================
    // Clock, timeout, verdict
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Bus and measuring tasks
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(q & m, e)
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic gap(output int n);
        n = 0;
        do @(posedge clk); while (sys_tick !== 1'b1 && cycles < 20000);
        do begin @(posedge clk); n++; end while (sys_tick !== 1'b1 && n < 400);
    endtask
    task automatic count(input int len, output int s, output int l,
        output int f);
        s = 0;
        l = 0;
        f = 0;
        repeat (len) begin
            @(posedge clk);
            s += (sys_tick === 1'b1);
            l += (slow_periph_tick === 1'b1);
            f += (fp_t === 1'b1);
        end
    endtask
    task automatic req(input logic h, input logic w);
        @(posedge clk);
        halt_req <= h;
        wake_req <= w;
        @(posedge clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        step(3);
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        step(3);
        rstn <= 1'b1;
        rd_chk(REG_SYSCLK, 32'hFF, 32'h0);
        rd_chk(REG_FASTRC, 32'hD, 32'h1);
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
        `CHK({wx_spd, frc_r, src_r, hresp}, 4'hE)
        for (int f = 1; f < 4; f++) begin
            wr(REG_FASTRC, 32'(f * 4 + 1));
            step(2);
            `CHK(fsel, (f == 3) ? 2'h2 : 2'(f))
        end
        wr(REG_FASTRC, 32'h0);
        step(2);
        `CHK(frc_r, 1'b0)
        wr(REG_FASTRC, 32'h1);
        for (int n = 0; n < 7; n++) begin
            wr(REG_SYSCLK, 32'(n << 5));
            gap(g);
            gap(g);
            `CHK(g, 3 << n)
        end
        $display("test reset, rc and divider done");
        // Crystal picked while off: no switch
        wr(REG_SYSCLK, 32'h08);
        gap(g);
        gap(g);
        `CHK(g, 192)
        wr(REG_FASTXTAL, 32'h1);
        step(400);
        rd_chk(REG_STAT, 32'h8, 32'h8);
        gap(g);
        gap(g);
        `CHK(g, 2)
        $display("test fast crystal done");
        wr(REG_WATCH, 32'h3);
        rd_chk(REG_WATCH, 32'h4, 32'h0);
        `CHK(wx_r, 1'b1)
        step(60);
        rd_chk(REG_WATCH, 32'h4, 32'h4);
        wr(REG_WATCH, 32'h1);
        rd_chk(REG_WATCH, 32'h6, 32'h4);
        wr(REG_WATCH, 32'h0);
        wr(REG_WATCH, 32'h1);
        step(150);
        rd_chk(REG_WATCH, 32'h4, 32'h4);
        wr(REG_WATCH, 32'h3);
        wr(REG_SYSCLK, 32'hE4);
        step(40);
        rd_chk(REG_STAT, 32'h4, 32'h4);
        gap(g);
        gap(g);
        `CHK(g, 5)
        wr(REG_WATCH, 32'h1);
        step(2);
        `CHK(wx_spd, 1'b1)
        count(100, ns, nl, nf);
        `CHK(nl, 20)
        wr(REG_SYSCLK, 32'hE0);
        step(40);
        rd_chk(REG_STAT, 32'h4, 32'h0);
        gap(g);
        gap(g);
        `CHK(g, 7)
        $display("test slow sources done");
        wr(REG_PINS, 32'h3);
        step(2);
        `CHK({pin_a, pin_b}, 2'h3)
        wr(REG_PINS, 32'h0);
        step(2);
        `CHK({pin_a, pin_b}, 2'h0)
        ce <= 1'b0;
        req(1'b1, 1'b0);
        `CHK(cpu_halted, 1'b0)
        ce <= 1'b1;
        wr(REG_SYSCLK, 32'h08);
        step(40);
        req(1'b1, 1'b0);
        rd_chk(REG_STAT, 32'h60, 32'h60);
        `CHK({cpu_halted, src_r, fx_r}, 3'h4)
        count(50, ns, nl, nf);
        `CHK(ns, 0)
        wdt_enable <= 1'b1;
        step(3);
        `CHK(src_r, 1'b1)
        req(1'b0, 1'b1);
        `CHK(cpu_halted, 1'b0)
        wr(REG_SYSCLK, 32'h0A);
        req(1'b1, 1'b0);
        rd_chk(REG_STAT, 32'h60, 32'h20);
        `CHK(fx_r, 1'b1)
        count(40, ns, nl, nf);
        `CHK(nf, 20)
        $display("test pins and halt modes done");
        summarize();
    end
endmodule // tb_oss_top
